// ==== hw/crpc_regs.v ====
// sample-rate divisor and pll programming registers on the control port
//
// Behaviour
// - dac divisor code sits in rate register bits 3..0, resets to zero, code zero means undivided.
// - bit 7 of pll register a enables the pll, reset value zero.
// - ratio field bits 6..3 decodes 0 as 16, 1 as 17, others as themselves, resets to 0010.
// - pre-division field bits 2..0 decodes 0 as 8, others as themselves, resets to 000.
// - integer multiplier in bits 7..2 of pll register b is its binary code 1..63, resets to one.
// - fraction is 14 bits, its eight upper bits fill the fraction high register, reset zero.
// - the six lower fraction bits sit in bits 7..2 of the fraction low register, reset zero.
// - a datapath bit picks the base sample rate, 48 kHz when clear, 44.1 kHz when set.
// - these registers answer only while page zero is active, set by writing page bit zero.
`timescale 1ns/10ps
`include "crpc_map.vh"
module crpc_regs #(
  parameter AW = 7                        // control port address width
) (
  input  wire          core_clk,          // register clock
  input  wire          rst,               // async reset, active high
  input  wire          wr_en,             // write strobe, one cycle
  input  wire          rd_en,             // read strobe, one cycle
  input  wire [AW-1:0] addr,              // register address within page
  input  wire [7:0]    wr_data,           // write data
  output reg  [7:0]    rd_data,           // read data, registered
  output wire          page_one,          // page one active
  output wire [3:0]    dac_div_code,      // dac divisor code
  output wire [2:0]    dac_div_value,     // dac divisor 1..6, 0 for reserved codes
  output wire          base_sample_rate,  // 0: 48 kHz, 1: 44.1 kHz
  output wire          pll_enable,        // pll on
  output wire [4:0]    pll_ratio,         // decoded ratio 2..17
  output wire [3:0]    pll_prediv,        // decoded pre-division 1..8
  output wire [5:0]    pll_int_mul,       // integer multiplier
  output reg  [13:0]   pll_frac           // fraction as seen by the pll
);

  // control-port state; decoded fields are held in flops so that every
  // field output comes straight from a register
  reg        page_r;        // active page, 0 selects page zero
  reg  [3:0] dacdiv_r;      // dac divisor code
  reg  [2:0] divval_r;      // decoded dac divisor
  reg        base_r;        // base sample rate select
  reg  [5:0] dpath_lo_r;    // datapath bits 6..1, plain storage
  reg        pllen_r;       // pll enable
  reg  [3:0] ratio_r;       // ratio code as written
  reg  [4:0] ratio_val_r;   // decoded ratio
  reg  [2:0] prediv_r;      // pre-division code as written
  reg  [3:0] prediv_val_r;  // decoded pre-division
  reg  [5:0] intmul_r;      // integer multiplier
  reg  [7:0] frach_r;       // fraction high part, staged until the low write
  reg  [5:0] fracl_r;       // fraction low part, kept for readback
  reg  [7:0] rd_data_nxt;   // readback mux

  // one write strobe per register
  wire       wr_page;
  wire       wr_rate;
  wire       wr_dpath;
  wire       wr_plla;
  wire       wr_pllb;
  wire       wr_frach;
  wire       wr_fracl;

  // raw address match, shared by the write and the read decode
  function at_ofs;
    input [AW-1:0] a;
    input [6:0]    ofs;
    begin
      at_ofs = (a == ofs[AW-1:0]);
    end
  endfunction

  // page-zero qualified match; the page is an argument so that @* sees it
  function hit;
    input          pg;
    input [AW-1:0] a;
    input [6:0]    ofs;
    begin
      hit = ~pg && at_ofs(a, ofs);
    end
  endfunction

  // ratio code to ratio: the two lowest codes stand for 16 and 17
  function [4:0] ratio_dec;
    input [3:0] code;
    begin
      if (code == `CRPC_RATIO_C16)
        ratio_dec = `CRPC_RATIO_V16;
      else if (code == `CRPC_RATIO_C17)
        ratio_dec = `CRPC_RATIO_V17;
      else
        ratio_dec = {1'b0, code};
    end
  endfunction

  // pre-division code to divider: code zero stands for 8
  function [3:0] prediv_dec;
    input [2:0] code;
    begin
      if (code == `CRPC_PREDIV_C8)
        prediv_dec = `CRPC_PREDIV_V8;
      else
        prediv_dec = {1'b0, code};
    end
  endfunction

  // dac divisor: codes pair up from 1 (1,2 -> 2; 3,4 -> 3 ...); reserved codes
  // give zero so that a bad write is visible downstream rather than aliased
  function [2:0] div_dec;
    input [3:0] code;
    begin
      if (code > `CRPC_DACDIV_LAST)
        div_dec = `CRPC_DIV_RSVD;
      else if (code == `CRPC_DACDIV_UNITY)
        div_dec = `CRPC_DIV_ONE;
      else
        div_dec = code[3:1] + {2'h0, code[0]} + `CRPC_DIV_ONE;
    end
  endfunction

  // the page register answers on both pages, all others only on page zero
  assign wr_page  = wr_en && at_ofs(addr, `CRPC_OFS_PAGE);
  assign wr_rate  = wr_en && hit(page_r, addr, `CRPC_OFS_RATE);
  assign wr_dpath = wr_en && hit(page_r, addr, `CRPC_OFS_DPATH);
  assign wr_plla  = wr_en && hit(page_r, addr, `CRPC_OFS_PLLA);
  assign wr_pllb  = wr_en && hit(page_r, addr, `CRPC_OFS_PLLB);
  assign wr_frach = wr_en && hit(page_r, addr, `CRPC_OFS_FRACH);
  assign wr_fracl = wr_en && hit(page_r, addr, `CRPC_OFS_FRACL);

  // page select; only bit 0 is kept, the rest reads zero
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      page_r <= `CRPC_RST_PAGE;
    end else if (wr_page) begin
      page_r <= wr_data[`CRPC_BIT_PAGE];
    end
  end

  // dac divisor code and its decode, both loaded on the same edge
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dacdiv_r <= `CRPC_RST_DACDIV;
      divval_r <= `CRPC_RST_DIVVAL;
    end else if (wr_rate) begin
      dacdiv_r <= wr_data[`CRPC_DACDIV_HI:`CRPC_DACDIV_LO];
      divval_r <= div_dec(wr_data[`CRPC_DACDIV_HI:`CRPC_DACDIV_LO]);
    end
  end

  // datapath register: base rate bit plus plain storage for its neighbours
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      base_r     <= `CRPC_RST_BASE;
      dpath_lo_r <= `CRPC_RST_DPLO;
    end else if (wr_dpath) begin
      base_r     <= wr_data[`CRPC_BIT_BASE];
      dpath_lo_r <= wr_data[`CRPC_DPLO_HI:`CRPC_DPLO_LO];
    end
  end

  // pll register a: enable, ratio and pre-division, codes and decodes together
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pllen_r      <= `CRPC_RST_PLLEN;
      ratio_r      <= `CRPC_RST_RATIO;
      ratio_val_r  <= `CRPC_RST_RATIO_V;
      prediv_r     <= `CRPC_RST_PREDIV;
      prediv_val_r <= `CRPC_RST_PREDIV_V;
    end else if (wr_plla) begin
      pllen_r      <= wr_data[`CRPC_BIT_PLLEN];
      ratio_r      <= wr_data[`CRPC_RATIO_HI:`CRPC_RATIO_LO];
      ratio_val_r  <= ratio_dec(wr_data[`CRPC_RATIO_HI:`CRPC_RATIO_LO]);
      prediv_r     <= wr_data[`CRPC_PREDIV_HI:`CRPC_PREDIV_LO];
      prediv_val_r <= prediv_dec(wr_data[`CRPC_PREDIV_HI:`CRPC_PREDIV_LO]);
    end
  end

  // integer multiplier; the two reserved low bits are dropped on write
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      intmul_r <= `CRPC_RST_INTMUL;
    end else if (wr_pllb) begin
      intmul_r <= wr_data[`CRPC_INTMUL_HI:`CRPC_INTMUL_LO];
    end
  end

  // fraction high part, held back from the pll until the low write
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frach_r <= `CRPC_RST_FRACH;
    end else if (wr_frach) begin
      frach_r <= wr_data;
    end
  end

  // fraction low part, kept only for readback
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fracl_r <= `CRPC_RST_FRACL;
    end else if (wr_fracl) begin
      fracl_r <= wr_data[`CRPC_FRACL_HI:`CRPC_FRACL_LO];
    end
  end

  // the pll picks up the fraction only on the low-part write, so a lone high
  // write never tears it; a low write alone reuses the last staged high part
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pll_frac <= {`CRPC_RST_FRACH, `CRPC_RST_FRACL};
    end else if (wr_fracl) begin
      pll_frac <= {frach_r, wr_data[`CRPC_FRACL_HI:`CRPC_FRACL_LO]};
    end
  end

  // readback mux; reserved bits, unmapped addresses and all but the page register on page one read zero
  always @* begin
    rd_data_nxt = `CRPC_RST_RDATA;
    if (at_ofs(addr, `CRPC_OFS_PAGE)) begin
      rd_data_nxt = {7'h00, page_r};
    end else if (hit(page_r, addr, `CRPC_OFS_RATE)) begin
      rd_data_nxt = {4'h0, dacdiv_r};
    end else if (hit(page_r, addr, `CRPC_OFS_PLLA)) begin
      rd_data_nxt = {pllen_r, ratio_r, prediv_r};
    end else if (hit(page_r, addr, `CRPC_OFS_PLLB)) begin
      rd_data_nxt = {intmul_r, 2'h0};
    end else if (hit(page_r, addr, `CRPC_OFS_FRACH)) begin
      rd_data_nxt = frach_r;
    end else if (hit(page_r, addr, `CRPC_OFS_FRACL)) begin
      rd_data_nxt = {fracl_r, 2'h0};
    end else if (hit(page_r, addr, `CRPC_OFS_DPATH)) begin
      rd_data_nxt = {base_r, dpath_lo_r, 1'b0};
    end
  end

  // readback register; holds its value between read strobes
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data <= `CRPC_RST_RDATA;
    end else if (rd_en) begin
      rd_data <= rd_data_nxt;
    end
  end

  // field outputs toward the clock datapath, all straight from flops
  assign page_one         = page_r;
  assign dac_div_code     = dacdiv_r;
  assign dac_div_value    = divval_r;
  assign base_sample_rate = base_r;
  assign pll_enable       = pllen_r;
  assign pll_ratio        = ratio_val_r;
  assign pll_prediv       = prediv_val_r;
  assign pll_int_mul      = intmul_r;

endmodule

// ==== hw/crpc_map.vh ====
// register offsets, field positions and reset values for the rate and pll configuration block
`ifndef CRPC_MAP_VH
`define CRPC_MAP_VH
`define CRPC_OFS_PAGE        7'h00
`define CRPC_OFS_RATE        7'h02
`define CRPC_OFS_PLLA        7'h03
`define CRPC_OFS_PLLB        7'h04
`define CRPC_OFS_FRACH       7'h05
`define CRPC_OFS_FRACL       7'h06
`define CRPC_OFS_DPATH       7'h07
`define CRPC_RST_DACDIV      4'h0
`define CRPC_RST_PLLEN       1'h0
`define CRPC_RST_RATIO       4'h2
`define CRPC_RST_PREDIV      3'h0
`define CRPC_RST_INTMUL      6'h01
`define CRPC_RST_FRACH       8'h00
`define CRPC_RST_FRACL       6'h00
`define CRPC_RATIO_C16       4'h0
`define CRPC_RATIO_C17       4'h1
`define CRPC_RATIO_V16       5'h10
`define CRPC_RATIO_V17       5'h11
`define CRPC_PREDIV_C8       3'h0
`define CRPC_PREDIV_V8       4'h8
`define CRPC_DACDIV_LAST     4'hA
`define CRPC_BIT_PLLEN       7
`define CRPC_BIT_BASE        7
`define CRPC_BIT_PAGE        0
`define CRPC_RST_PAGE        1'h0
`define CRPC_RST_BASE        1'h0
`define CRPC_RST_DPLO        6'h00
`define CRPC_RST_RDATA       8'h00
`define CRPC_RST_RATIO_V     5'h02
`define CRPC_RST_PREDIV_V    4'h8
`define CRPC_RST_DIVVAL      3'h1
`define CRPC_DACDIV_UNITY    4'h0
`define CRPC_DIV_ONE         3'h1
`define CRPC_DIV_RSVD        3'h0
`define CRPC_DACDIV_HI       3
`define CRPC_DACDIV_LO       0
`define CRPC_RATIO_HI        6
`define CRPC_RATIO_LO        3
`define CRPC_PREDIV_HI       2
`define CRPC_PREDIV_LO       0
`define CRPC_INTMUL_HI       7
`define CRPC_INTMUL_LO       2
`define CRPC_FRACL_HI        7
`define CRPC_FRACL_LO        2
`define CRPC_DPLO_HI         6
`define CRPC_DPLO_LO         1
`endif

// ==== test/crpc_regs_sva.sv ====
// port assertions for the rate and pll register block
`timescale 1ns/10ps
module crpc_regs_sva #(parameter AW = 7) (
  input wire          core_clk, rst, wr_en, rd_en, page_one,
  input wire [AW-1:0] addr,
  input wire [7:0]    wr_data, rd_data,
  input wire [3:0]    dac_div_code, pll_prediv,
  input wire [2:0]    dac_div_value,
  input wire          pll_enable, base_sample_rate,
  input wire [4:0]    pll_ratio,
  input wire [5:0]    pll_int_mul,
  input wire [13:0]   pll_frac
);
  // only page zero writes reach these registers
  wire w = wr_en && !page_one;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_dac_code: assert property (w && addr == 7'h02 |=> dac_div_code == $past(wr_data[3:0]))
    else $error("dac code not stored");
  a_dac_unity: assert property (dac_div_code == 4'h0 |-> dac_div_value == 3'h1)
    else $error("code zero not undivided");
  a_pll_on: assert property (w && addr == 7'h03 |=> pll_enable == $past(wr_data[7]))
    else $error("pll enable not stored");
  a_ratio_dec: assert property (w && addr == 7'h03 |=> pll_ratio ==
    ($past(wr_data[6:4]) == 3'h0 ? 5'h10 + $past(wr_data[3]) : $past(wr_data[6:3])))
    else $error("ratio decode wrong");
  a_prediv_dec: assert property (w && addr == 7'h03 |=> pll_prediv ==
    ($past(wr_data[2:0]) == 3'h0 ? 4'h8 : $past(wr_data[2:0])))
    else $error("prediv decode wrong");
  a_int_mul: assert property (w && addr == 7'h04 |=> pll_int_mul == $past(wr_data[7:2]))
    else $error("multiplier not stored");
  a_frac_low: assert property (w && addr == 7'h06 |=> pll_frac[5:0] == $past(wr_data[7:2]))
    else $error("fraction low bits wrong");
  // a half-written fraction must never reach the pll
  a_frac_hold: assert property (!(w && addr == 7'h06) |=> $stable(pll_frac))
    else $error("fraction moved without low write");
  a_page_guard: assert property (wr_en && page_one && addr == 7'h03 |=> $stable(pll_enable))
    else $error("page one write leaked");
  a_page_read: assert property (rd_en && page_one && addr == 7'h03 |=> rd_data == 8'h00)
    else $error("page one read not zero");
  a_base_rate: assert property (w && addr == 7'h07 |=> base_sample_rate == $past(wr_data[7]))
    else $error("base rate not stored");
endmodule
bind crpc_regs crpc_regs_sva #(.AW(AW)) i_crpc_regs_sva (.*);

// ==== test/crpc_regs_tb.sv ====
// self-checking bench for the rate and pll register block
`timescale 1ns/10ps
module crpc_regs_tb;
  reg         core_clk, rst, wr_en, rd_en;
  reg  [6:0]  addr;
  reg  [7:0]  wr_data, lf, q[$];
  wire [7:0]  rd_data;
  wire [3:0]  dac_div_code, pll_prediv;
  wire [2:0]  dac_div_value;
  wire [4:0]  pll_ratio;
  wire [5:0]  pll_int_mul;
  wire [13:0] pll_frac;
  wire        page_one, base_sample_rate, pll_enable;
  integer     miscompares, n_tests, cyc, i;
  crpc_regs i_crpc_regs (.core_clk(core_clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .page_one(page_one),
    .dac_div_code(dac_div_code), .dac_div_value(dac_div_value), .pll_frac(pll_frac),
    .base_sample_rate(base_sample_rate), .pll_enable(pll_enable), .pll_ratio(pll_ratio),
    .pll_prediv(pll_prediv), .pll_int_mul(pll_int_mul));
  function [7:0] nx(input [7:0] v);
    nx = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task chk(input [15:0] g, input [15:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // one assignment per falling edge, so back-to-back calls never race
  task drv(input w, input r, input [6:0] a, input [7:0] d);
    begin
      @(negedge core_clk);
      {wr_en, rd_en, addr, wr_data} = {w, r, a, d};
    end
  endtask
  task nop;
    drv(1'b0, 1'b0, 7'h00, 8'h00);
  endtask
  task rd(input [6:0] a, input [7:0] e);
    begin
      drv(1'b0, 1'b1, a, 8'h00);
      q.push_back(e);
    end
  endtask
  task summarize;
    begin
      $display("n_tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial forever #5 core_clk = ~core_clk;
  // read data lands one edge after the strobe
  always @(posedge core_clk) if (rd_en) begin
    #1 chk(rd_data, q.pop_front());
  end
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      miscompares = miscompares + 1;
      summarize;
    end
  end
  initial begin
    {core_clk, rst, miscompares, n_tests, cyc, lf} = {2'b01, 96'h0, 8'h41};
    {wr_en, rd_en, addr, wr_data} = 17'h0;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    rd(7'h02, 8'h00);
    rd(7'h03, 8'h10);
    rd(7'h04, 8'h04);
    rd(7'h06, 8'h00);
    nop;
    chk({pll_enable, pll_ratio, pll_prediv, pll_int_mul}, {1'b0, 5'h02, 4'h8, 6'h01});
    chk(pll_frac, 16'h0000);
    $display("reset test done");
    for (i = 0; i < 16; i = i + 1) begin
      lf = nx(lf);
      drv(1'b1, 1'b0, 7'h03, {lf[7], i[3:0], lf[2:0]});
      nop;
      chk({pll_enable, pll_ratio, pll_prediv},
        {lf[7], i < 2 ? 5'h10 + i[4:0] : i[4:0], lf[2:0] == 3'h0 ? 4'h8 : {1'b0, lf[2:0]}});
      rd(7'h03, {lf[7], i[3:0], lf[2:0]});
    end
    for (i = 0; i < 11; i = i + 1) begin
      drv(1'b1, 1'b0, 7'h02, {4'h0, i[3:0]});
      nop;
      chk(dac_div_code, i[3:0]);
      chk(dac_div_value, (i + 1) / 2 + 1);
      rd(7'h02, {4'h0, i[3:0]});
      lf = nx(lf);
      drv(1'b1, 1'b0, 7'h04, {lf[5:1], 3'h4});
      rd(7'h04, {lf[5:1], 3'h4});
      chk(pll_int_mul, {lf[5:1], 1'b1});
    end
    $display("divisor and ratio tests done");
    // high then low with no gap; the fraction is checked while the low write is offered
    drv(1'b1, 1'b0, 7'h05, 8'h9C);
    drv(1'b1, 1'b0, 7'h06, 8'h3C);
    chk(pll_frac, 16'h0000);
    drv(1'b1, 1'b0, 7'h05, 8'h27);
    chk(pll_frac, 16'd9999);
    drv(1'b1, 1'b0, 7'h06, 8'h0C);
    chk(pll_frac, 16'd9999);
    rd(7'h05, 8'h27);
    chk(pll_frac, 16'h09C3);
    rd(7'h06, 8'h0C);
    drv(1'b1, 1'b0, 7'h03, 8'h2A);
    drv(1'b1, 1'b0, 7'h00, 8'h01);
    drv(1'b1, 1'b0, 7'h03, 8'hFF);
    rd(7'h03, 8'h00);
    rd(7'h00, 8'h01);
    chk({page_one, pll_enable}, 16'h2);
    drv(1'b1, 1'b0, 7'h00, 8'h00);
    rd(7'h03, 8'h2A);
    rd(7'h7F, 8'h00);
    drv(1'b1, 1'b0, 7'h07, 8'h80);
    nop;
    chk({page_one, base_sample_rate}, 16'h1);
    rd(7'h07, 8'h80);
    nop;
    $display("fraction and page tests done");
    summarize;
  end
endmodule
